// >>> cpu_model.sv
// CPU core stand-in: counts executed cycles, retires handler returns
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   cpu_exec,
    input  wire logic   ret_req,
    output logic        return_from_irq_instr,
    output logic [15:0] n_exec
);
    // =====================================================
    // A return only retires in an active cycle, like a real core
    always_ff @(posedge clk) begin
        if (rst) begin
            return_from_irq_instr <= 1'b0;
            n_exec                <= 16'h0000;
        end else begin
            return_from_irq_instr <= ret_req && cpu_exec && !return_from_irq_instr;
            n_exec                <= n_exec + {15'h0000, cpu_exec};
        end
    end
endmodule
`default_nettype wire

// >>> irq_flags_rate_ctrl.sv
// Interrupt enable/flag registers with reduced instruction rate control
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1 - While reduced rate is on, CPU runs one cycle in every N.
// R2 - Ratio select 100 gives 1:32, 001 gives 1:4.
// R3 - Peripherals and flag logic keep running every clock while throttled.
// R4 - Next instruction is still prefetched ahead of each active cycle.
// R5 - With wake bit clear, handler runs at the reduced rate.
// R6 - With wake bit set, an interrupt clears reduced rate at once.
// R7 - On recovery, prefetched instruction runs first, then vectoring follows.
// R8 - Return from interrupt with resume bit set re-enables reduced rate.
// R9 - Enable 0: timer0 bit 5, pin change bit 4, pin bit 0.
// R10 - Enable 0 sources need only global; others need group enable too.
// R11 - Flag 8 holds width, period, overflow flags for both timers.
// R12 - Overflow flags are set by hardware and cleared only by software.
// R13 - Flags set on their condition regardless of any enable bit.
// R14 - Software should clear stale flags before setting an enable.
// R15 - Request goes out when an enabled flag meets its global enables.
module irq_flags_rate_ctrl (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire irq_rate_pkg::apb_req_s apb_req,
    output irq_rate_pkg::apb_rsp_s     apb_rsp,
    input  wire logic                  timer0_ovf_evt,
    input  wire logic                  pin_change_evt,
    input  wire logic                  ext_irq_pin,
    input  wire logic [5:0]            meas_evt,
    input  wire logic                  return_from_irq_instr,
    output logic                       irq_vector,
    output logic                       irq_line,
    output logic                       reduced_rate_on,
    output logic                       cpu_exec,
    output logic                       cpu_fetch
);
    import irq_rate_pkg::*;

    ctrl_state_s st;
    ctrl_state_s next_st;

    // ========================================================
    // Helpers

    // Sticky flag update: write-one-to-clear, a new event wins
    function automatic logic [7:0] sticky_update(
        input logic [7:0] cur,
        input logic [7:0] set_bits,
        input logic [7:0] clr_bits,
        input logic [7:0] mask
    );
        sticky_update = ((cur & ~clr_bits) | set_bits) & mask;
    endfunction

    // Byte lanes collapse to the low byte; upper bits read as zero
    function automatic logic [31:0] low_byte(input logic [7:0] v);
        low_byte = {24'h00_0000, v};
    endfunction

    // ========================================================
    // Bus decode and event collection
    logic       acc;
    logic       wr;
    logic       rd;
    logic       hit;
    logic [7:0] wbyte;
    logic [7:0] set0;
    logic [7:0] set8;
    logic [7:0] clr0;
    logic [7:0] clr8;
    logic       pin_rise;
    logic       pend0;
    logic       pend8;
    logic       irq_pend;
    logic       irq_arrive;

    always_comb begin
        // Access phase is answered after one wait state
        acc   = apb_req.psel && apb_req.penable && !st.apb.pready;
        wr    = acc && apb_req.pwrite;
        rd    = acc && !apb_req.pwrite;
        wbyte = apb_req.pwdata[7:0];
        unique case (apb_req.paddr)
            OFS_IRQ_ENABLE_0, OFS_IRQ_FLAGS_8, OFS_IRQ_ENABLE_8,
            OFS_IRQ_CONTROL, OFS_RATE_CONTROL, OFS_IRQ_FLAGS_0: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Pin edge only once second and third stages agree on a new level
    assign pin_rise = (st.pin_sync[1] == st.pin_sync[2])
                   && st.pin_sync[2] && !st.pin_level;

    // Hardware set terms, independent of any enable bit
    always_comb begin
        set0 = 8'h00;
        set0[BIT_TIMER0_OVF] = timer0_ovf_evt; // R13
        set0[BIT_PIN_CHANGE] = pin_change_evt; // R13
        set0[BIT_EXT_PIN]    = pin_rise; // R13
        set8 = {2'b00, meas_evt}; // R11 R13
        clr0 = (wr && hit && apb_req.paddr == OFS_IRQ_FLAGS_0)
             ? wbyte : 8'h00;
        clr8 = (wr && hit && apb_req.paddr == OFS_IRQ_FLAGS_8)
             ? wbyte : 8'h00;
    end

    // ========================================================
    // Interrupt qualification
    // Group 0 bypasses the peripheral group enable; group 8 needs it
    assign pend0    = |(st.flag0 & st.en0); // R15
    assign pend8    = |(st.flag8 & st.en8); // R15
    assign irq_pend = st.global_en
                   && (pend0 || (st.group_en && pend8)); // R10 R15
    assign irq_arrive = irq_pend && !st.irq_prev;

    // ========================================================
    // Next-state logic
    always_comb begin
        next_st = st;

        // Pin synchroniser, three stages
        next_st.pin_sync = {st.pin_sync[1:0], ext_irq_pin};
        if (st.pin_sync[1] == st.pin_sync[2]) begin
            next_st.pin_level = st.pin_sync[2];
        end

        // Flags update every clock, throttled or not
        next_st.flag0 = sticky_update(st.flag0, set0, clr0,
                                      MASK_REG0); // R3 R13
        next_st.flag8 = sticky_update(st.flag8, set8, clr8,
                                      MASK_REG8); // R12 R3

        // Register writes
        if (wr && hit) begin
            unique case (apb_req.paddr)
                OFS_IRQ_ENABLE_0: begin
                    next_st.en0 = wbyte & MASK_REG0; // R9
                end
                OFS_IRQ_ENABLE_8: begin
                    next_st.en8 = wbyte & MASK_REG8;
                end
                OFS_IRQ_CONTROL: begin
                    next_st.global_en = wbyte[BIT_GLOBAL_EN];
                    next_st.group_en  = wbyte[BIT_GROUP_EN];
                end
                OFS_RATE_CONTROL: begin
                    next_st.rate_on       = wbyte[BIT_RATE_ON];
                    next_st.wake_on_irq   = wbyte[BIT_WAKE_ON_IRQ];
                    next_st.resume_on_ret = wbyte[BIT_RESUME_RET];
                    next_st.ratio_sel     = wbyte[POS_RATIO_SEL +: 3];
                end
                default: begin
                    // Flag registers handled above
                end
            endcase
        end

        // Hardware rate changes override a same-cycle software write
        if (return_from_irq_instr && st.resume_on_ret) begin
            next_st.rate_on = 1'b1; // R8
        end
        // Without wake, rate_on stays and the handler runs throttled
        if (irq_arrive && st.wake_on_irq && st.rate_on) begin
            next_st.rate_on = 1'b0; // R6
            // One full-speed cycle for the prefetched instruction
            next_st.drain   = 1'b1; // R7
        end else begin
            next_st.drain   = 1'b0;
        end

        // Vectoring held back while the prefetched instruction drains
        next_st.irq_vec  = irq_pend && !next_st.drain; // R7 R5
        next_st.irq_prev = irq_pend;

        // Bus answer
        next_st.apb.pready  = acc;
        next_st.apb.pslverr = acc && !hit;
        next_st.apb.prdata  = ZERO_WORD;
        if (rd && hit) begin
            unique case (apb_req.paddr)
                OFS_IRQ_ENABLE_0: next_st.apb.prdata = low_byte(st.en0);
                OFS_IRQ_FLAGS_8:  next_st.apb.prdata = low_byte(st.flag8);
                OFS_IRQ_ENABLE_8: next_st.apb.prdata = low_byte(st.en8);
                OFS_IRQ_FLAGS_0:  next_st.apb.prdata = low_byte(st.flag0);
                OFS_IRQ_CONTROL: begin
                    next_st.apb.prdata[BIT_GLOBAL_EN] = st.global_en;
                    next_st.apb.prdata[BIT_GROUP_EN]  = st.group_en;
                end
                OFS_RATE_CONTROL: begin
                    next_st.apb.prdata[BIT_RATE_ON]     = st.rate_on;
                    next_st.apb.prdata[BIT_WAKE_ON_IRQ] = st.wake_on_irq;
                    next_st.apb.prdata[BIT_RESUME_RET]  = st.resume_on_ret;
                    next_st.apb.prdata[POS_RATIO_SEL +: 3] = st.ratio_sel;
                end
                default: begin
                    next_st.apb.prdata = ZERO_WORD;
                end
            endcase
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st.en0           <= RST_REG8;
            st.flag0         <= RST_REG8;
            st.en8           <= RST_REG8;
            st.flag8         <= RST_REG8;
            st.global_en     <= 1'b0;
            st.group_en      <= 1'b0;
            st.rate_on       <= 1'b0;
            st.wake_on_irq   <= 1'b0;
            st.resume_on_ret <= 1'b0;
            st.ratio_sel     <= RST_RATIO;
            st.pin_sync      <= 3'h0;
            st.pin_level     <= 1'b0;
            st.irq_prev      <= 1'b0;
            st.drain         <= 1'b0;
            st.irq_vec       <= 1'b0;
            st.apb           <= '{prdata: ZERO_WORD, pready: 1'b0,
                                  pslverr: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // Instruction gate; peripherals never see it
    rate_gate u_rate_gate (
        .clk       (clk),
        .rst       (rst),
        .reduced   (st.rate_on),
        .ratio_sel (st.ratio_sel),
        .cpu_exec  (cpu_exec),
        .cpu_fetch (cpu_fetch)
    ); // R1 R4

    // Outputs straight from state flops
    assign apb_rsp         = st.apb;
    assign irq_vector      = st.irq_vec;
    assign irq_line        = st.irq_vec;
    assign reduced_rate_on = st.rate_on;

endmodule

`default_nettype wire

// >>> irq_props.sv
// Port checker for the interrupt flag and reduced-rate block
`timescale 1ns/1ps
`default_nettype none
module irq_props (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire irq_rate_pkg::apb_req_s apb_req,
    input wire irq_rate_pkg::apb_rsp_s apb_rsp,
    input wire logic                   return_from_irq_instr,
    input wire logic                   irq_vector,
    input wire logic                   irq_line,
    input wire logic                   reduced_rate_on,
    input wire logic                   cpu_exec,
    input wire logic                   cpu_fetch
);
    import irq_rate_pkg::*;
    logic wr_rate;
    logic bad_addr;
    // =====================================================
    // Helpers: a taken rate-control write, an unmapped address
    assign wr_rate  = apb_req.psel && apb_req.penable && !apb_rsp.pready
                      && apb_req.pwrite && apb_req.paddr == OFS_RATE_CONTROL;
    assign bad_addr = apb_req.paddr[1:0] != 2'b00
                      || apb_req.paddr > OFS_IRQ_FLAGS_0;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_taken;
        apb_req.psel && apb_req.penable && !apb_rsp.pready;
    endsequence
    sequence s_slow_exec;
        reduced_rate_on [*4] ##0 cpu_exec;
    endsequence
    // =====================================================
    // Protocol and behaviour
    a_pready_answer: assert property (s_taken |=> apb_rsp.pready)
        else $error("pready missing after access");
    a_pready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    a_pready_cause: assert property ($rose(apb_rsp.pready)
        |-> $past(apb_req.psel && apb_req.penable))
        else $error("pready without access");
    a_slverr_unmapped: assert property (apb_rsp.pready
        |-> apb_rsp.pslverr == bad_addr)
        else $error("pslverr wrong for address");
    a_exec_full_speed: assert property (!reduced_rate_on [*3] |-> cpu_exec)
        else $error("exec gated at full speed");
    a_exec_isolated: assert property (s_slow_exec |=> !cpu_exec)
        else $error("two exec cycles in reduced mode");
    a_fetch_then_exec: assert property (reduced_rate_on [*3] ##0 cpu_fetch
        |=> cpu_exec)
        else $error("fetch not followed by exec");
    a_rate_set_cause: assert property ($rose(reduced_rate_on)
        |-> $past(return_from_irq_instr) || $past(wr_rate))
        else $error("reduced rate set without cause");
    a_irq_line_vec: assert property (irq_line == irq_vector)
        else $error("irq line and vector differ");
    // Hardware exit from reduced rate leaves one drain cycle before vectoring
    a_drain_no_vec: assert property ($fell(reduced_rate_on)
        && !$past(wr_rate) |-> !irq_vector)
        else $error("vectoring before prefetched instruction");
endmodule
bind irq_flags_rate_ctrl irq_props i_props (
    .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .return_from_irq_instr(return_from_irq_instr),
    .irq_vector(irq_vector), .irq_line(irq_line),
    .reduced_rate_on(reduced_rate_on), .cpu_exec(cpu_exec),
    .cpu_fetch(cpu_fetch));
`default_nettype wire

// >>> irq_rate_pkg.sv
// Shared constants and carriers for the interrupt flag and reduced-rate block
package irq_rate_pkg;

    // ========================================================
    // Register byte offsets on the APB window
    localparam logic [7:0] OFS_IRQ_ENABLE_0   = 8'h00;
    localparam logic [7:0] OFS_IRQ_FLAGS_8    = 8'h04;
    localparam logic [7:0] OFS_IRQ_ENABLE_8   = 8'h08;
    localparam logic [7:0] OFS_IRQ_CONTROL    = 8'h0C;
    localparam logic [7:0] OFS_RATE_CONTROL   = 8'h10;
    localparam logic [7:0] OFS_IRQ_FLAGS_0    = 8'h14;

    // ========================================================
    // Enable/flag register 0 fields
    localparam int BIT_TIMER0_OVF  = 5;
    localparam int BIT_PIN_CHANGE  = 4;
    localparam int BIT_EXT_PIN     = 0;
    localparam logic [7:0] MASK_REG0 = 8'h31;

    // Flag register 8 fields (measurement timers)
    localparam int BIT_MEAS2_WIDTH  = 5;
    localparam int BIT_MEAS2_PERIOD = 4;
    localparam int BIT_MEAS2_OVF    = 3;
    localparam int BIT_MEAS1_WIDTH  = 2;
    localparam int BIT_MEAS1_PERIOD = 1;
    localparam int BIT_MEAS1_OVF    = 0;
    localparam logic [7:0] MASK_REG8 = 8'h3F;

    // Interrupt control register fields
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_GROUP_EN  = 6;

    // Rate control register fields
    localparam int BIT_RATE_ON     = 7;
    localparam int BIT_WAKE_ON_IRQ = 6;
    localparam int BIT_RESUME_RET  = 5;
    localparam int POS_RATIO_SEL   = 0;

    // ========================================================
    // Reset values
    localparam logic [7:0] RST_REG8  = 8'h00;
    localparam logic [2:0] RST_RATIO = 3'h0;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic       exec;
        logic       fetch;
    } rate_state_s;

    typedef struct packed {
        logic [7:0] en0;
        logic [7:0] flag0;
        logic [7:0] en8;
        logic [7:0] flag8;
        logic       global_en;
        logic       group_en;
        logic       rate_on;
        logic       wake_on_irq;
        logic       resume_on_ret;
        logic [2:0] ratio_sel;
        logic [2:0] pin_sync;
        logic       pin_level;
        logic       irq_prev;
        logic       drain;
        logic       irq_vec;
        apb_rsp_s   apb;
    } ctrl_state_s;

endpackage

// >>> rate_gate.sv
// Instruction-cycle gate that lets one CPU cycle through in every N
`timescale 1ns/1ps
`default_nettype none

module rate_gate (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       reduced,
    input  wire logic [2:0] ratio_sel,
    output logic            cpu_exec,
    output logic            cpu_fetch
);
    import irq_rate_pkg::*;

    rate_state_s st;
    rate_state_s next_st;
    logic [7:0]  last;

    // ========================================================
    // Period select: N = 2^(sel+1), so 001 is 1:4, 100 is 1:32
    always_comb begin
        last = 8'((9'h002 << ratio_sel) - 9'h001);
        next_st = st;
        if (!reduced) begin
            // Full speed: every cycle fetches and executes
            next_st.cnt   = 8'h00;
            next_st.exec  = 1'b1;
            next_st.fetch = 1'b1;
        end else begin
            next_st.cnt   = (st.cnt >= last) ? 8'h00 : 8'(st.cnt + 8'h01); // R1 R2
            next_st.exec  = (next_st.cnt == 8'h00); // R1
            // Prefetch sits one cycle ahead of the active one
            next_st.fetch = (next_st.cnt == last); // R4
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{cnt: 8'h00, exec: 1'b1, fetch: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign cpu_exec  = st.exec;
    assign cpu_fetch = st.fetch;

endmodule

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the interrupt flag and reduced-rate block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irq_rate_pkg::*;
    logic        clk;
    logic        rst;
    apb_req_s    req;
    apb_rsp_s    rsp;
    logic        tmr_evt;
    logic        chg_evt;
    logic        pin;
    logic [5:0]  meas;
    logic        ret_req;
    logic        ret;
    logic        irq_vec;
    logic        irq_line;
    logic        rate_on;
    logic        exec;
    logic        fetch;
    logic [15:0] n_exec;
    logic [15:0] n0;
    logic [31:0] rd;
    logic        err;
    int          n_fail;
    int          comparisons;
    irq_flags_rate_ctrl i_dut (
        .clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .timer0_ovf_evt(tmr_evt), .pin_change_evt(chg_evt),
        .ext_irq_pin(pin), .meas_evt(meas),
        .return_from_irq_instr(ret), .irq_vector(irq_vec),
        .irq_line(irq_line), .reduced_rate_on(rate_on),
        .cpu_exec(exec), .cpu_fetch(fetch));
    cpu_model i_cpu (
        .clk(clk), .rst(rst), .cpu_exec(exec), .ret_req(ret_req),
        .return_from_irq_instr(ret), .n_exec(n_exec));
    // =====================================================
    // Clock, checks and bus tasks
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic print_verdict;
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic chk1(input logic s, input logic e);
        chk({31'h0000_0000, s}, {31'h0000_0000, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Holds the request until pready is sampled; no fixed wait assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int   t;
        logic done;
        t = 0;
        done = 1'b0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        // Look at the answer mid-cycle so the next rising edge samples it
        do begin
            @(negedge clk);
            t++;
            done = (rsp.pready === 1'b1);
            rd = rsp.prdata;
            err = rsp.pslverr;
            @(posedge clk);
        end while (!done && t < 40);
        if (!done)
            n_fail++;
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    // One-cycle source pulses: timer0, pin change, six measurement events
    task automatic ev(input logic [7:0] v);
        @(posedge clk);
        {tmr_evt, chg_evt, meas} <= v;
        @(posedge clk);
        {tmr_evt, chg_evt, meas} <= 8'h00;
    endtask
    // =====================================================
    // Hang guard, far longer than the sequence needs
    initial begin
        #400_000;
        n_fail++;
        print_verdict;
    end
    initial begin
        rst = 1'b1;
        req = '0;
        {tmr_evt, chg_evt, meas} = 8'h00;
        pin = 1'b0;
        ret_req = 1'b0;
        n_fail = 0;
        comparisons = 0;
        cyc(4);
        rst <= 1'b0;
        rdx(OFS_IRQ_ENABLE_0, 32'h0000_0000);
        rdx(OFS_IRQ_FLAGS_8, 32'h0000_0000);
        wr(OFS_IRQ_ENABLE_0, 32'h0000_00FF);
        rdx(OFS_IRQ_ENABLE_0, 32'h0000_0031);
        apb(1'b1, 8'h18, 32'h0000_00FF);
        chk1(err, 1'b1);
        // Throttle 1:4, then flags must still set every clock
        wr(OFS_RATE_CONTROL, 32'h0000_0081);
        cyc(8);
        n0 = n_exec;
        cyc(40);
        chk({16'h0000, n_exec - n0}, 32'h0000_000A);
        ev(8'h3F);
        cyc(2);
        rdx(OFS_IRQ_FLAGS_8, 32'h0000_003F);
        wr(OFS_IRQ_FLAGS_8, 32'h0000_0009);
        rdx(OFS_IRQ_FLAGS_8, 32'h0000_0036);
        wr(OFS_IRQ_FLAGS_8, 32'h0000_0036);
        ev(8'hC0);
        pin <= 1'b1;
        cyc(6);
        pin <= 1'b0;
        rdx(OFS_IRQ_FLAGS_0, 32'h0000_0031);
        wr(OFS_IRQ_FLAGS_0, 32'h0000_0031);
        wr(OFS_RATE_CONTROL, 32'h0000_0084);
        cyc(40);
        n0 = n_exec;
        cyc(64);
        chk({16'h0000, n_exec - n0}, 32'h0000_0002);
        // Group enable needed for register 8 sources only
        wr(OFS_IRQ_CONTROL, 32'h0000_0080);
        wr(OFS_IRQ_ENABLE_8, 32'h0000_0001);
        ev(8'h01);
        cyc(4);
        chk1(irq_line, 1'b0);
        wr(OFS_IRQ_CONTROL, 32'h0000_00C0);
        cyc(3);
        chk1(irq_line, 1'b1);
        wr(OFS_IRQ_FLAGS_8, 32'h0000_0001);
        cyc(3);
        chk1(irq_line, 1'b0);
        wr(OFS_IRQ_CONTROL, 32'h0000_0080);
        wr(OFS_IRQ_ENABLE_0, 32'h0000_0020);
        ev(8'h80);
        cyc(4);
        chk1(irq_line, 1'b1);
        chk1(rate_on, 1'b1);
        wr(OFS_IRQ_FLAGS_0, 32'h0000_0020);
        // Wake on interrupt, then resume on return
        wr(OFS_RATE_CONTROL, 32'h0000_00E1);
        ev(8'h80);
        cyc(4);
        chk1(rate_on, 1'b0);
        chk1(irq_vec, 1'b1);
        wr(OFS_IRQ_FLAGS_0, 32'h0000_0020);
        ret_req <= 1'b1;
        for (int i = 0; i < 20 && ret !== 1'b1; i++)
            @(posedge clk);
        ret_req <= 1'b0;
        cyc(2);
        chk1(rate_on, 1'b1);
        print_verdict;
    end
endmodule
`default_nettype wire
